// ### pkg/rla_pkg.sv
// constants and types for the real-time link input alignment block
// *****************************************************************
// *****************************************************************
package rla_pkg;
    // word geometry in bytes for each line rate
    localparam logic [4:0] BYTES_LOW = 5'h1c;
    localparam logic [4:0] BYTES_HIGH = 5'h00;
    localparam int WORD_BITS = 256;
    // fixed byte positions inside one crossing word
    localparam logic [4:0] POS_BOUNDARY = 5'h00;
    localparam logic [4:0] POS_BUNCH = 5'h01;
    // control characters: boundary marker and zero-fill comma
    localparam logic [7:0] K_BOUNDARY = 8'hbc;
    localparam logic [7:0] K_FILL = 8'h3c;
    localparam logic [7:0] FILL_VALUE = 8'h00;
    // crc-8 over every byte of the word but the last
    localparam logic [7:0] CRC_INIT = 8'hff;
    localparam logic [7:0] CRC_POLY = 8'h07;
    // reset values
    localparam logic [7:0] BUNCH_RESET = 8'h00;
    localparam logic [4:0] POS_RESET = 5'h00;

    typedef enum logic {
        ST_HUNT,
        ST_LOCKED
    } rla_state_t;
endpackage

// ### hdl/rla_crc8.sv
// running crc-8 over the bytes of one crossing word
`timescale 1ns/1ps
module rla_crc8 (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // byte stream
    input wire logic clear,
    input wire logic step,
    input wire logic [7:0] data,
    // running checksum of the bytes stepped since the last clear
    output logic [7:0] crc_q
);
    function automatic logic [7:0] crc_byte(input logic [7:0] crc, input logic [7:0] d);
        logic [7:0] c;
        c = crc ^ d;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ rla_pkg::CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    logic [7:0] base;
    assign base = clear ? rla_pkg::CRC_INIT : crc_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            crc_q <= rla_pkg::CRC_INIT;
        end else if (step) begin
            crc_q <= crc_byte(base, data);
        end else begin
            crc_q <= base;
        end
    end
endmodule // rla_crc8

// ### hdl/rla_align.sv
// framing, alignment and checking of one real-time input link
`timescale 1ns/1ps
module rla_align (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // decoded symbols from the multi_gigabit_transceiver
    input wire logic rx_valid,
    input wire logic rx_is_k,
    input wire logic [7:0] rx_byte,
    // configuration: 0 selects 11.2 Gb/s, 1 selects 12.8 Gb/s
    input wire logic rate_high,
    input wire logic quad_rate_high,
    // bunch_crossing toggle from the timing_trigger_control_input pin
    input wire logic bunch_crossing_toggle,
    // aligned word, released on the bunch_crossing tick
    output logic [255:0] word_q,
    output logic word_valid_q,
    output logic [7:0] bunch_count_q,
    // status
    output logic locked_q,
    output logic crc_err_q,
    output logic comma_err_q,
    output logic bunch_err_q,
    output logic rate_err_q
);
    // *****************************************************************
    // bunch crossing tick
    // *****************************************************************
    logic s1_q, s2_q, s3_q, bc_level_q, bc_tick;
    // the stages keep following the pin through reset; the pin is never reset itself
    always_ff @(posedge clock) begin
        s1_q <= bunch_crossing_toggle;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end
    // a change only counts once two late stages agree, rejecting glitches
    // the level tracks the pin during reset, so a pin left high gives no false tick
    always_ff @(posedge clock) begin
        if (rst) begin
            bc_level_q <= s3_q;
        end else if (s2_q == s3_q) begin
            bc_level_q <= s3_q;
        end
    end
    assign bc_tick = (s2_q == s3_q) && (s3_q != bc_level_q);

    // *****************************************************************
    // symbol classification
    // *****************************************************************
    logic [4:0] last_pos;
    logic is_boundary, is_fill, mid_fill_ok, take;
    logic [7:0] data_val;
    rla_pkg::rla_state_t state_q;
    logic [4:0] pos_q;

    // byte count wraps to zero for the 32-byte word, so last is count-1
    assign last_pos = (rate_high ? rla_pkg::BYTES_HIGH : rla_pkg::BYTES_LOW) - 5'h01;
    assign is_boundary = rx_is_k && (rx_byte == rla_pkg::K_BOUNDARY);
    assign is_fill = rx_is_k && (rx_byte == rla_pkg::K_FILL);
    // fill commas stand in for zero bytes of empty fields only
    assign mid_fill_ok = (pos_q != rla_pkg::POS_BUNCH) && (pos_q != last_pos);
    assign data_val = is_fill ? rla_pkg::FILL_VALUE : rx_byte;
    assign take = rx_valid && !rate_err_q;

    // *****************************************************************
    // word framing
    // *****************************************************************
    logic crc_clear, crc_step, word_done, frame_bad;
    logic [7:0] crc_run;
    logic [255:0] asm_q;

    assign crc_clear = take && is_boundary &&
        (state_q == rla_pkg::ST_HUNT || pos_q == rla_pkg::POS_BOUNDARY);
    assign crc_step = take && (state_q == rla_pkg::ST_LOCKED || is_boundary) &&
        (pos_q != last_pos);
    // boundary marker anywhere but byte 0, or missing at byte 0
    assign frame_bad = take && (state_q == rla_pkg::ST_LOCKED) &&
        ((pos_q == rla_pkg::POS_BOUNDARY) != is_boundary);
    assign word_done = take && (state_q == rla_pkg::ST_LOCKED) && !frame_bad &&
        (pos_q == last_pos);

    rla_crc8 u_crc (
        .clock(clock),
        .rst(rst),
        .clear(crc_clear),
        .step(crc_step),
        .data(data_val),
        .crc_q(crc_run)
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= rla_pkg::ST_HUNT;
            pos_q <= rla_pkg::POS_RESET;
        end else if (rate_err_q) begin
            // a quad running mixed rates cannot be framed reliably
            state_q <= rla_pkg::ST_HUNT;
            pos_q <= rla_pkg::POS_RESET;
        end else if (take) begin
            unique case (state_q)
                rla_pkg::ST_HUNT: begin
                    if (is_boundary) begin
                        state_q <= rla_pkg::ST_LOCKED;
                        pos_q <= rla_pkg::POS_BUNCH;
                    end
                end
                rla_pkg::ST_LOCKED: begin
                    if (frame_bad) begin
                        state_q <= rla_pkg::ST_HUNT;
                        pos_q <= rla_pkg::POS_RESET;
                    end else if (pos_q == last_pos) begin
                        pos_q <= rla_pkg::POS_RESET;
                    end else begin
                        pos_q <= pos_q + 5'h01;
                    end
                end
            endcase
        end
    end

    // byte i lands in bits 8i+7..8i; the top 32 bits stay zero at low rate
    always_ff @(posedge clock) begin
        if (rst) begin
            asm_q <= '0;
        end else if (take && (state_q == rla_pkg::ST_LOCKED || is_boundary)) begin
            if (crc_clear) begin
                asm_q <= '0;
                asm_q[7:0] <= data_val;
            end else begin
                asm_q[pos_q*8 +: 8] <= data_val;
            end
        end
    end

    // *****************************************************************
    // checks on each received byte and on a completed word
    // *****************************************************************
    logic [7:0] rx_bunch, prev_bunch_q;
    logic have_prev_q, crc_bad, bunch_bad, comma_bad;
    logic [1:0] words_in_bc_q;

    assign rx_bunch = asm_q[rla_pkg::POS_BUNCH*8 +: 8];
    assign crc_bad = word_done && (rx_byte != crc_run || rx_is_k);
    assign bunch_bad = word_done && have_prev_q && (rx_bunch != prev_bunch_q + 8'h01);
    assign comma_bad = frame_bad ||
        (take && state_q == rla_pkg::ST_LOCKED && rx_is_k && !is_boundary &&
         !(is_fill && mid_fill_ok));

    always_ff @(posedge clock) begin
        if (rst) begin
            prev_bunch_q <= rla_pkg::BUNCH_RESET;
            have_prev_q <= 1'b0;
        end else if (state_q == rla_pkg::ST_HUNT) begin
            have_prev_q <= 1'b0;
        end else if (word_done) begin
            prev_bunch_q <= rx_bunch;
            have_prev_q <= 1'b1;
        end
    end

    // exactly one word per crossing; a word ending on the tick counts for the next
    always_ff @(posedge clock) begin
        if (rst) begin
            words_in_bc_q <= 2'h0;
        end else if (bc_tick) begin
            words_in_bc_q <= {1'b0, word_done};
        end else if (word_done && words_in_bc_q != 2'h3) begin
            words_in_bc_q <= words_in_bc_q + 2'h1;
        end
    end

    // *****************************************************************
    // outputs
    // *****************************************************************
    logic [255:0] held_q;
    logic held_ok_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            held_q <= '0;
            held_ok_q <= 1'b0;
        end else if (word_done) begin
            held_q <= asm_q;
            held_q[last_pos*8 +: 8] <= rx_byte;
            held_ok_q <= !crc_bad;
        end else if (bc_tick || state_q == rla_pkg::ST_HUNT) begin
            held_ok_q <= 1'b0;
        end
    end

    // all links release their words on the same tick, which aligns them
    always_ff @(posedge clock) begin
        if (rst) begin
            word_q <= '0;
            word_valid_q <= 1'b0;
            bunch_count_q <= rla_pkg::BUNCH_RESET;
        end else begin
            word_valid_q <= bc_tick && held_ok_q;
            if (bc_tick && held_ok_q) begin
                word_q <= held_q;
                bunch_count_q <= held_q[rla_pkg::POS_BUNCH*8 +: 8];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            locked_q <= 1'b0;
            crc_err_q <= 1'b0;
            comma_err_q <= 1'b0;
            bunch_err_q <= 1'b0;
            rate_err_q <= 1'b0;
        end else begin
            locked_q <= (state_q == rla_pkg::ST_LOCKED) && !frame_bad;
            crc_err_q <= crc_bad;
            comma_err_q <= comma_bad;
            bunch_err_q <= bunch_bad ||
                (bc_tick && locked_q && have_prev_q && words_in_bc_q != 2'h1);
            rate_err_q <= rate_high != quad_rate_high;
        end
    end
endmodule // rla_align

// ### test/rla_assertions.sv
// port checks for the link aligner
`timescale 1ns/1ps
module rla_assertions (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // link side
    input wire logic rx_valid,
    input wire logic rx_is_k,
    input wire logic [7:0] rx_byte,
    input wire logic rate_high,
    input wire logic bunch_crossing_toggle,
    // word side
    input wire logic [255:0] word_q,
    input wire logic word_valid_q,
    input wire logic [7:0] bunch_count_q,
    input wire logic locked_q,
    input wire logic crc_err_q,
    input wire logic rate_err_q
);
    logic tog_q;
    logic [3:0] since_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // cycles since the crossing pin moved; saturates so a stalled pin never wraps
    always_ff @(posedge clock) begin
        tog_q <= bunch_crossing_toggle;
        if (rst || bunch_crossing_toggle != tog_q) begin
            since_q <= 4'h0;
        end else if (since_q != 4'hf) begin
            since_q <= since_q + 4'h1;
        end
    end
    AST_CRC_PULSE: assert property (crc_err_q |=> !crc_err_q)
        else $error("crc error pulse too long");
    AST_RATE_UNLOCK: assert property (rate_err_q [*3] |-> !locked_q)
        else $error("locked with mixed quad rate");
    AST_LOCK_MARK: assert property ($rose(locked_q) |->
        $past(rx_valid && rx_is_k && rx_byte == rla_pkg::K_BOUNDARY, 2))
        else $error("lock without boundary marker");
    AST_TICK_RELEASE: assert property (word_valid_q |-> since_q inside {[2:6]})
        else $error("word released off the crossing tick");
    AST_BUNCH_FIELD: assert property (word_valid_q |-> bunch_count_q == word_q[15:8])
        else $error("bunch count not byte one");
    AST_WORD_HEAD: assert property (word_valid_q |-> word_q[7:0] == rla_pkg::K_BOUNDARY)
        else $error("word not headed by marker");
    AST_LOW_TOP: assert property (word_valid_q && !rate_high |-> word_q[255:224] == 32'h0)
        else $error("low rate word too wide");
    AST_WORD_HOLD: assert property (!word_valid_q && !$past(rst) |-> $stable(word_q))
        else $error("word changed between releases");
    cover property (word_valid_q && rate_high);
    cover property (crc_err_q);
    cover property (rate_err_q);
endmodule // rla_assertions
bind rla_align rla_assertions chk (.clock, .rst, .rx_valid, .rx_is_k, .rx_byte, .rate_high,
    .bunch_crossing_toggle, .word_q, .word_valid_q, .bunch_count_q, .locked_q, .crc_err_q,
    .rate_err_q);

// ### test/rla_src_model.sv
// far-end source: frames one crossing word per pin toggle
`timescale 1ns/1ps
module rla_src_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // scenario controls
    input wire logic en,
    input wire logic rate_high,
    input wire logic bad_crc,
    input wire logic bad_comma,
    input wire logic bad_bunch,
    // symbol lane and crossing pin
    output logic rx_valid = 1'b0,
    output logic rx_is_k = 1'b0,
    output logic [7:0] rx_byte = 8'h00,
    output logic bunch_crossing_toggle = 1'b0,
    // last whole word sent, fill counted as zero
    output logic [255:0] last_word
);
    logic [255:0] word;
    logic [7:0] crc;
    logic [7:0] bc;
    logic [7:0] v;
    logic rst_s, en_s, hi_s, crc_s, comma_s, bunch_s;
    int idx;
    // controls are taken at the edge, so a bench change just after it never races the lane
    always @(posedge clock) begin
        {rst_s, en_s, hi_s, crc_s, comma_s, bunch_s} =
            {rst, en, rate_high, bad_crc, bad_comma, bad_bunch};
        #1;
        if (rst_s) begin
            idx = 0;
            bc = 8'h00;
            rx_valid = 1'b0;
            rx_byte = ~rx_byte;
        end else if (!en_s) begin
            idx = 0;
            rx_valid = 1'b1;
            rx_is_k = 1'b1;
            rx_byte = rla_pkg::K_FILL;
        end else begin
            if (idx == 0) begin
                word = '0;
                crc = rla_pkg::CRC_INIT;
                bunch_crossing_toggle = ~bunch_crossing_toggle;
            end
            v = (idx == 1) ? bc : (idx == 5) ? rla_pkg::FILL_VALUE : 8'(idx) + bc;
            if (idx == (hi_s ? 31 : 27))
                v = crc_s ? ~crc : crc;
            rx_valid = 1'b1;
            rx_is_k = idx == 0 || idx == 5 || (comma_s && idx == 9);
            rx_byte = rx_is_k ? (idx == 5 ? rla_pkg::K_FILL : rla_pkg::K_BOUNDARY) : v;
            if (idx == 0)
                v = rla_pkg::K_BOUNDARY;
            word[idx*8 +: 8] = v;
            for (int j = 7; j >= 0; j--)
                crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ v[j]) ? rla_pkg::CRC_POLY : 8'h00);
            idx = idx + 1;
            if (idx == (hi_s ? 32 : 28)) begin
                last_word = word;
                bc = bc + (bunch_s ? 8'h02 : 8'h01);
                idx = 0;
            end
        end
    end
endmodule // rla_src_model

// ### test/realtime_link_input_alignment_tb.sv
// self-checking bench for the link aligner
`timescale 1ns/1ps
module realtime_link_input_alignment_tb;
    logic clock = 1'b0, rst = 1'b1, en = 1'b0, rate_high = 1'b0, quad_rate_high = 1'b0;
    logic bad_crc = 1'b0, bad_comma = 1'b0, bad_bunch = 1'b0;
    logic rx_valid, rx_is_k, bct, word_valid_q, locked_q, crc_err_q, comma_err_q;
    logic bunch_err_q, rate_err_q;
    logic [7:0] rx_byte, bunch_count_q;
    logic [255:0] word_q, sent;
    int errors = 0, comparisons = 0, n_crc, n_comma, n_bunch, gap;
    always #25 clock = ~clock;
    rla_src_model src (.clock, .rst, .en, .rate_high, .bad_crc, .bad_comma, .bad_bunch,
        .rx_valid, .rx_is_k, .rx_byte, .bunch_crossing_toggle(bct), .last_word(sent));
    rla_align uut (.clock, .rst, .rx_valid, .rx_is_k, .rx_byte, .rate_high, .quad_rate_high,
        .bunch_crossing_toggle(bct), .word_q, .word_valid_q, .bunch_count_q, .locked_q,
        .crc_err_q, .comma_err_q, .bunch_err_q, .rate_err_q);
    always @(posedge clock) begin
        n_crc += (crc_err_q === 1'b1);
        n_comma += (comma_err_q === 1'b1);
        n_bunch += (bunch_err_q === 1'b1);
    end
    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // reset held three cycles, then start-up commas, then the word stream
    task automatic start(input logic hi);
        cyc(1);
        {rst, en, bad_crc, bad_comma, bad_bunch} = 5'h10;
        {rate_high, quad_rate_high} = {hi, hi};
        cyc(3);
        rst = 1'b0;
        cyc(8);
        en = 1'b1;
        cyc(4);
        {n_crc, n_comma, n_bunch} = 0;
        check(locked_q, 1'b1);
    endtask
    task automatic wait_valid();
        gap = 0;
        do begin
            cyc(1);
            gap++;
        end while (word_valid_q !== 1'b1 && gap < 80);
    endtask
    task automatic t_stream(input logic hi);
        start(hi);
        wait_valid();
        repeat (3) begin
            check(word_q, sent);
            check(bunch_count_q, sent[15:8]);
            wait_valid();
            check(gap, hi ? 32 : 28);
        end
        check(n_crc + n_comma + n_bunch, 0);
        $display("stream test done, rate_high %0d", hi);
    endtask
    // each fault is held for exactly one word of the stream
    task automatic t_faults();
        for (int f = 0; f < 3; f++) begin
            start(1'b0);
            {bad_crc, bad_comma, bad_bunch} = 3'h4 >> f;
            cyc(28);
            {bad_crc, bad_comma, bad_bunch} = 3'h0;
            cyc(90);
            check({n_crc, n_comma, n_bunch}, 96'h1 << (64 - 32 * f));
            check(locked_q, 1'b1);
        end
        $display("fault test done");
    endtask
    task automatic t_rate();
        start(1'b1);
        quad_rate_high = 1'b0;
        cyc(4);
        check({rate_err_q, locked_q}, 2'h2);
        quad_rate_high = 1'b1;
        cyc(70);
        check({rate_err_q, locked_q}, 2'h1);
        $display("rate test done");
    endtask
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        t_stream(1'b0);
        t_stream(1'b1);
        t_faults();
        t_rate();
        summarize();
    end
    initial begin
        #400000;
        errors++;
        summarize();
    end
endmodule // realtime_link_input_alignment_tb
